// ---- design/ebs_pkg.sv ----
// Package for the external bus cycle sequencer and I/O strobe block.
// Assumes a single clock domain and a core that issues one request at a time.
package ebs_pkg;

  // ****************************************************************
  // Widths and address slicing
  // ****************************************************************
  localparam int ADDR_W       = 20;
  localparam int IO_ADDR_W    = 16;
  localparam int DATA_W       = 8;
  localparam int NUM_STROBES  = 8;
  localparam int NUM_CS       = 3;
  localparam int SLICE_MSB    = 15;
  localparam int SLICE_LSB    = 13;

  // ****************************************************************
  // Strobe modes, two bits per strobe
  // ****************************************************************
  typedef enum logic [1:0] {
    EBS_STB_CS = 2'h0,
    EBS_STB_RD = 2'h1,
    EBS_STB_WR = 2'h2,
    EBS_STB_RW = 2'h3
  } ebs_stb_mode_e;

  // ****************************************************************
  // Bus cycle states
  // ****************************************************************
  typedef enum logic [1:0] {
    EBS_IDLE  = 2'h0,
    EBS_SPEC  = 2'h1,
    EBS_ADDR  = 2'h2,
    EBS_STRB  = 2'h3
  } ebs_state_e;

  // Request from the core
  typedef struct packed {
    logic                  is_io;
    logic                  write;
    logic [ADDR_W-1:0]     addr;
    logic [NUM_CS-1:0]     cs_sel;
    logic [DATA_W-1:0]     wdata;
  } ebs_req_s;

  // Pins toward the external bus
  typedef struct packed {
    logic [ADDR_W-1:0]     addr;
    logic [NUM_CS-1:0]     cs_n;
    logic                  oe_n;
    logic                  we_n;
    logic [DATA_W-1:0]     dout;
    logic                  dout_en;
  } ebs_bus_s;

  localparam logic [NUM_CS-1:0] CS_IDLE  = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

endpackage : ebs_pkg

// ---- design/ebs_bus_cycle.sv ----
// External bus cycle sequencer with eight programmable I/O strobes.
// Assumes the core holds its request stable while req_valid_i is high and
// that the port pin configuration comes from the core's own registers.
//
// How it works
// RL1 - Memory and I/O cycles run through the very same state sequence.
// RL2 - The first clock of a cycle drives the address and the chip select.
// RL3 - A read asserts output enable one clock after address and select.
// RL4 - A write drives data and write enable one clock after address.
// RL5 - A cycle may open with a one-clock speculative fetch address.
// RL6 - After that clock the final address and select are driven.
// RL7 - Enables wait a full clock after the final address and select.
// RL8 - The speculative fetch is dropped when a data cycle is needed.
// RL9 - External logic must not clock on select or address edges.
// RL10 - Each strobe decodes its own 8K slice of the I/O space.
// RL11 - Each strobe is a chip select, read, write or read/write strobe.
// RL12 - Each port pin selects between parallel data and its strobe.
// RL13 - A strobe fires only on I/O cycles within its slice.
// RL14 - A strobe reaches its pin only if the pin direction is output.
// RL15 - Read or write strobes follow the enables, select type the select.
`timescale 1ns/1ns

module ebs_bus_cycle
#(
  parameter int NUM_STROBES = ebs_pkg::NUM_STROBES
)
(
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        req_valid_i,
  input  wire ebs_pkg::ebs_req_s           req_i,
  input  wire logic                        spec_valid_i,
  input  wire logic [ebs_pkg::ADDR_W-1:0]  spec_addr_i,
  input  wire logic [ebs_pkg::NUM_CS-1:0]  spec_cs_sel_i,
  input  wire logic [ebs_pkg::DATA_W-1:0]  bus_din_i,
  input  wire logic [2*NUM_STROBES-1:0]    stb_mode_i,
  input  wire logic [NUM_STROBES-1:0]      port_sel_i,
  input  wire logic [NUM_STROBES-1:0]      port_dir_i,
  input  wire logic [NUM_STROBES-1:0]      port_data_i,
  output logic                             req_ready_o,
  output logic                             rd_valid_o,
  output logic [ebs_pkg::DATA_W-1:0]       rd_data_o,
  output ebs_pkg::ebs_bus_s                bus_o,
  output logic [NUM_STROBES-1:0]           strobe_capable_port_pins_o,
  output logic [NUM_STROBES-1:0]           strobe_capable_port_pins_oe_o
);

  // ****************************************************************
  // Cycle state
  // ****************************************************************
  ebs_pkg::ebs_state_e             state_reg;
  ebs_pkg::ebs_state_e             state_next;
  ebs_pkg::ebs_req_s               cur_reg;
  logic [NUM_STROBES-1:0]          pin_next;
  logic [NUM_STROBES-1:0]          stb_act;
  logic [ebs_pkg::NUM_CS-1:0]      cs_dec;

  // Low-active select: the bitwise inverse of the select bits, with no index decode
  function automatic logic [ebs_pkg::NUM_CS-1:0] cs_of
  (
    input logic [ebs_pkg::NUM_CS-1:0] sel
  );
    cs_of = ~sel;
  endfunction : cs_of

  assign cs_dec = cs_of(req_i.cs_sel);

  // Next state; memory and I/O share one path
  always_comb
  begin
    state_next = state_reg;
    // RL1 same sequence
    case (state_reg)
      ebs_pkg::EBS_IDLE:
      begin
        // RL5 speculative first clock
        if (spec_valid_i)
          state_next = ebs_pkg::EBS_SPEC;
        else if (req_valid_i)
          state_next = ebs_pkg::EBS_ADDR;
      end
      ebs_pkg::EBS_SPEC:
      begin
        // RL8 abandon fetch when data needed
        if (req_valid_i)
          state_next = ebs_pkg::EBS_ADDR;
        else
          state_next = ebs_pkg::EBS_IDLE;
      end
      // RL7 full clock before enables
      ebs_pkg::EBS_ADDR: state_next = ebs_pkg::EBS_STRB;
      ebs_pkg::EBS_STRB: state_next = ebs_pkg::EBS_IDLE;
      default:           state_next = ebs_pkg::EBS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_reg <= ebs_pkg::EBS_IDLE;
    else
      state_reg <= state_next;
  end

  // Latch the real request when its address phase begins
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cur_reg <= '0;
    else if (state_next == ebs_pkg::EBS_ADDR)
      cur_reg <= req_i;
  end

  // Request accepted on entry to the address phase
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      req_ready_o <= 1'b0;
    else
      req_ready_o <= (state_next == ebs_pkg::EBS_ADDR) && req_valid_i &&
                     !req_ready_o;
  end

  // ****************************************************************
  // Bus pins
  // ****************************************************************
  // Address and select change only at phase entry, so glitches stay
  // confined to the one speculative clock.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      bus_o.addr    <= ebs_pkg::ADDR_RST;
      bus_o.cs_n    <= ebs_pkg::CS_IDLE;
      bus_o.oe_n    <= 1'b1;
      bus_o.we_n    <= 1'b1;
      bus_o.dout    <= ebs_pkg::DATA_RST;
      bus_o.dout_en <= 1'b0;
    end
    else
    begin
      bus_o.oe_n    <= 1'b1;
      bus_o.we_n    <= 1'b1;
      bus_o.dout_en <= 1'b0;
      case (state_next)
        ebs_pkg::EBS_SPEC:
        begin
          // RL5 fetch address for one clock
          bus_o.addr <= spec_addr_i;
          bus_o.cs_n <= cs_of(spec_cs_sel_i);
        end
        ebs_pkg::EBS_ADDR:
        begin
          // RL2 address and select first
          // RL6 switch to final target
          bus_o.addr <= req_i.addr;
          bus_o.cs_n <= req_i.is_io ? ebs_pkg::CS_IDLE : cs_dec;
        end
        ebs_pkg::EBS_STRB:
        begin
          // RL3 read enable one clock later
          bus_o.oe_n    <= cur_reg.write;
          // RL4 write data and enable
          bus_o.we_n    <= !cur_reg.write;
          bus_o.dout    <= cur_reg.wdata;
          bus_o.dout_en <= cur_reg.write;
        end
        default:
          bus_o.cs_n <= ebs_pkg::CS_IDLE;
      endcase
    end
  end

  // Read data captured at the end of the enable clock
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= ebs_pkg::DATA_RST;
    end
    else
    begin
      rd_valid_o <= (state_reg == ebs_pkg::EBS_STRB) && !cur_reg.write;
      if ((state_reg == ebs_pkg::EBS_STRB) && !cur_reg.write)
        rd_data_o <= bus_din_i;
    end
  end

  // ****************************************************************
  // I/O strobes
  // ****************************************************************
  // Strobes are computed from the next state so the pin flop lines up
  // with the select and enable pins cycle for cycle.
  for (genvar g = 0; g < NUM_STROBES; g++)
  begin : g_stb
    logic hit;
    logic in_addr;
    logic in_strb;
    ebs_pkg::ebs_stb_mode_e mode;

    assign mode = ebs_pkg::ebs_stb_mode_e'(stb_mode_i[2*g +: 2]);
    // RL10 one 8K slice each
    // RL13 only I/O cycles in slice
    assign in_addr = (state_next == ebs_pkg::EBS_ADDR) && req_i.is_io &&
      (req_i.addr[ebs_pkg::SLICE_MSB:ebs_pkg::SLICE_LSB] == 3'(g));
    assign in_strb = (state_next == ebs_pkg::EBS_STRB) && cur_reg.is_io &&
      (cur_reg.addr[ebs_pkg::SLICE_MSB:ebs_pkg::SLICE_LSB] == 3'(g));

    // RL11 per-strobe mode
    // RL15 timing follows select or enables
    always_comb
    begin
      case (mode)
        ebs_pkg::EBS_STB_CS: hit = in_addr || in_strb;
        ebs_pkg::EBS_STB_RD: hit = in_strb && !cur_reg.write;
        ebs_pkg::EBS_STB_WR: hit = in_strb && cur_reg.write;
        ebs_pkg::EBS_STB_RW: hit = in_strb;
        default:             hit = 1'b0;
      endcase
    end

    assign stb_act[g] = hit;
    // RL12 parallel or strobe per pin
    assign pin_next[g] = port_sel_i[g] ? !stb_act[g] : port_data_i[g];
  end

  // Pin drivers; strobes are low active
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      strobe_capable_port_pins_o    <= '1;
      strobe_capable_port_pins_oe_o <= '0;
    end
    else
    begin
      strobe_capable_port_pins_o    <= pin_next;
      // RL14 strobe needs output direction
      strobe_capable_port_pins_oe_o <= port_dir_i;
    end
  end

endmodule : ebs_bus_cycle

// ---- dv/ebs_bus_cycle_sva.sv ----
// Concurrent checks on the bus cycle sequencer top-level ports.
// Assumes one clock and a synchronous, active-high reset.
`timescale 1ns/1ns

module ebs_bus_cycle_sva
#(
  parameter int NUM_STROBES = 8
)
(
  input wire logic                     clk_i,
  input wire logic                     sys_rst_i,
  input wire logic [2*NUM_STROBES-1:0] stb_mode_i,
  input wire logic [NUM_STROBES-1:0]   port_sel_i,
  input wire logic [NUM_STROBES-1:0]   port_data_i,
  input wire logic                     req_ready_o,
  input wire logic                     rd_valid_o,
  input wire ebs_pkg::ebs_bus_s        bus_o,
  input wire logic [NUM_STROBES-1:0]   strobe_capable_port_pins_o
);
  logic [NUM_STROBES-1:0] rd_mask;
  logic [NUM_STROBES-1:0] hit;
  logic [NUM_STROBES-1:0] pin;

  // Read-type strobes and the slice the bus address falls in
  always_comb
  begin
    for (int k = 0; k < NUM_STROBES; k++)
      rd_mask[k] = (stb_mode_i[2*k +: 2] == 2'h1);
    hit = NUM_STROBES'(1) << bus_o.addr[15:13];
    pin = strobe_capable_port_pins_o;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  en_addr_stable_a: assert property (
    !bus_o.oe_n || !bus_o.we_n |-> $stable(bus_o.addr) && $stable(bus_o.cs_n))
    else $error("enable with moving address");
  rd_after_take_a: assert property (
    $fell(bus_o.oe_n) |-> $past(req_ready_o))
    else $error("read enable not one clock after address");
  wr_after_take_a: assert property (
    $fell(bus_o.we_n) |-> bus_o.dout_en && $past(req_ready_o))
    else $error("write enable timing wrong");
  rd_one_clock_a: assert property (
    !bus_o.oe_n |=> bus_o.oe_n && rd_valid_o)
    else $error("read enable width or data valid wrong");
  data_with_we_a: assert property (
    bus_o.dout_en == !bus_o.we_n)
    else $error("data drive and write enable disagree");
  take_then_en_a: assert property (
    req_ready_o |=> !bus_o.oe_n || !bus_o.we_n)
    else $error("no enable after accepted request");
  slice_only_a: assert property (
    (~pin & $past(port_sel_i) & ~hit) == '0)
    else $error("strobe outside its slice");
  io_only_a: assert property (
    |(~pin & $past(port_sel_i)) |-> bus_o.cs_n == '1)
    else $error("strobe during a memory cycle");
  rd_strobe_oe_a: assert property (
    |(~pin & $past(port_sel_i) & $past(rd_mask)) |-> !bus_o.oe_n)
    else $error("read strobe without output enable");
  port_data_a: assert property (
    !$past(sys_rst_i) |->
      ((pin ^ $past(port_data_i)) & ~$past(port_sel_i)) == '0)
    else $error("parallel pin lost its data");

  rd_seen_c: cover property ($fell(bus_o.oe_n));
  wr_seen_c: cover property ($fell(bus_o.we_n));
  stb_seen_c: cover property (|(~pin & port_sel_i));
endmodule : ebs_bus_cycle_sva

// ---- dv/ebs_mem_model.sv ----
// Byte memory standing in for the external chips and peripherals.
// Assumes it sees the registered bus pins; answers within the enable clock.
`timescale 1ns/1ns

module ebs_mem_model
(
  input  wire logic                  clk_i,
  input  wire ebs_pkg::ebs_bus_s     bus_i,
  output logic [ebs_pkg::DATA_W-1:0] bus_din_o
);
  logic [7:0] mem_reg [256];
  logic [7:0] last_reg = 8'h00;

  // clock-only state
  // Stores only on the clock; select or address edges never advance it
  always_ff @(posedge clk_i)
  begin
    if (!bus_i.we_n)
      mem_reg[bus_i.addr[7:0]] <= bus_i.dout;
    if (!bus_i.oe_n)
      last_reg <= bus_din_o;
  end

  // Released bus shows the inverse of the last byte, not a stale copy
  assign bus_din_o = !bus_i.oe_n ? mem_reg[bus_i.addr[7:0]] : ~last_reg;
endmodule : ebs_mem_model

// ---- dv/tb_external_bus_cycle_and_io_strobes.sv ----
// Self-checking bench for the bus cycle sequencer and I/O strobes.
// Assumes the memory model answers reads; inputs move 1 ns after clk_i.
`timescale 1ns/1ns

module tb_external_bus_cycle_and_io_strobes;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, req_valid = 1'b0, spec_valid = 1'b0;
  ebs_pkg::ebs_req_s req = '0;
  ebs_pkg::ebs_bus_s bus;
  logic [19:0] spec_addr = 20'h00abc;
  logic [2:0]  spec_cs = 3'h4;
  logic [15:0] stb_mode = 16'h0000;
  logic [7:0]  din, rd_data, pins, pins_oe;
  logic [7:0]  port_sel = 8'hff, port_dir = 8'hff, port_data = 8'h00;
  logic        ready, rd_valid;
  int          err_count = 0, comparisons = 0;

  ebs_bus_cycle dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid), .req_i(req), .spec_valid_i(spec_valid),
    .spec_addr_i(spec_addr), .spec_cs_sel_i(spec_cs), .bus_din_i(din),
    .stb_mode_i(stb_mode), .port_sel_i(port_sel), .port_dir_i(port_dir),
    .port_data_i(port_data), .req_ready_o(ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .bus_o(bus), .strobe_capable_port_pins_o(pins),
    .strobe_capable_port_pins_oe_o(pins_oe));
  ebs_mem_model mem (.clk_i(clk_i), .bus_i(bus), .bus_din_o(din));

  // 250 MHz clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // One access; returns read data and pins in the address and enable clocks
  task automatic access(input logic io, wr, sp, input logic [19:0] a,
    input logic [7:0] d, output logic [7:0] rd, p1, p2);
    int n = 0;
    req = '{is_io: io, write: wr, addr: a, cs_sel: 3'h2, wdata: d};
    req_valid = 1'b1;
    spec_valid = sp;
    tick();
    if (sp)
    begin
      check(bus.addr, spec_addr);
      check(bus.cs_n, 3'(~spec_cs));
    end
    while (ready !== 1'b1 && n < 8)
    begin
      n++;
      tick();
    end
    if (ready !== 1'b1)
    begin
      err_count++;
      finish_test();
    end
    req_valid = 1'b0;
    spec_valid = 1'b0;
    check(bus.addr, a);
    check(bus.cs_n, io ? 3'h7 : 3'h5);
    p1 = pins;
    tick();
    check({bus.oe_n, bus.we_n}, {wr, !wr});
    if (wr)
      check(bus.dout, d);
    check(bus.dout_en, wr);
    p2 = pins;
    tick();
    check(rd_valid, !wr);
    rd = rd_data;
  endtask : access

  // Memory write then read back to back, then a speculative read and a speculative write with a read back
  task automatic mem_cycles();
    logic [7:0] rd, p1, p2;
    access(1'b0, 1'b1, 1'b0, 20'h4a5c3, 8'h96, rd, p1, p2);
    check(p1, 8'hff);
    check(p2, 8'hff);
    access(1'b0, 1'b0, 1'b0, 20'h4a5c3, 8'h00, rd, p1, p2);
    check(rd, 8'h96);
    access(1'b0, 1'b0, 1'b1, 20'h4a5c3, 8'h00, rd, p1, p2);
    check(rd, 8'h96);
    access(1'b0, 1'b1, 1'b1, 20'h4a5c4, 8'h5a, rd, p1, p2);
    access(1'b0, 1'b0, 1'b0, 20'h4a5c4, 8'h00, rd, p1, p2);
    check(rd, 8'h5a);
  endtask : mem_cycles

  // Speculative fetch with no data cycle behind it
  task automatic spec_drop();
    spec_valid = 1'b1;
    tick();
    check(bus.addr, spec_addr);
    spec_valid = 1'b0;
    tick();
    check(bus.cs_n, 3'h7);
    check(ready, 1'b0);
    tick();
    check({bus.oe_n, bus.we_n}, 2'h3);
  endtask : spec_drop

  // Every strobe mode, on an odd slice, for write and read
  task automatic io_modes();
    logic [7:0] rd, p1, p2, mk;
    for (int m = 0; m < 4; m++)
    begin
      stb_mode = {8{m[1:0]}};
      mk = 8'h01 << (2 * m + 1);
      for (int w = 1; w >= 0; w--)
      begin
        access(1'b1, w[0], 1'b0, {4'h0, 3'(2*m+1), 13'h0155}, 8'h3c,
          rd, p1, p2);
        check(p1, m == 0 ? 8'(~mk) : 8'hff);
        check(p2, (m == 0 || m == 3 || m == 1 + w) ? 8'(~mk) : 8'hff);
        if (w == 0)
          check(rd, 8'h3c);
      end
    end
  endtask : io_modes

  // Half the pins as parallel port, one strobe still active
  task automatic port_mix();
    logic [7:0] rd, p1, p2;
    port_sel = 8'h0f;
    port_data = 8'ha5;
    port_dir = 8'h3c;
    tick();
    tick();
    check(pins, 8'haf);
    check(pins_oe, 8'h3c);
    access(1'b1, 1'b0, 1'b0, 20'h04000, 8'h00, rd, p1, p2);
    check(p2, 8'hab);
  endtask : port_mix

  // Main sequence
  initial
  begin
    repeat (5) tick();
    sys_rst_i = 1'b0;
    mem_cycles();
    spec_drop();
    io_modes();
    port_mix();
    finish_test();
  end
endmodule : tb_external_bus_cycle_and_io_strobes

bind ebs_bus_cycle ebs_bus_cycle_sva #(.NUM_STROBES(NUM_STROBES)) chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .stb_mode_i(stb_mode_i),
  .port_sel_i(port_sel_i), .port_data_i(port_data_i),
  .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .bus_o(bus_o),
  .strobe_capable_port_pins_o(strobe_capable_port_pins_o));
